// >>> pkg/bdg_pkg.sv
// package for the binning/decimation geometry block: register map,
// field widths, limits and reset values.
// assumes an apb slave with 32-bit data and word-aligned registers.
package bdg_pkg;
  localparam int unsigned DIM_W = 16;
  localparam int unsigned FAC_W = 6;
  localparam int unsigned GAIN_W = 12;
  localparam int unsigned PIX_W = 12;
  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FACTOR = 8'h04;
  localparam logic [ADDR_W-1:0] REG_AOI_SIZE = 8'h08;
  localparam logic [ADDR_W-1:0] REG_AOI_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_ZONE_X = 8'h10;
  localparam logic [ADDR_W-1:0] REG_ZONE_Y = 8'h14;
  localparam logic [ADDR_W-1:0] REG_EFF_RES = 8'h18;
  localparam logic [ADDR_W-1:0] REG_EFF_AOI = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_EFF_AOFS = 8'h20;
  localparam logic [ADDR_W-1:0] REG_EFF_ZX = 8'h24;
  localparam logic [ADDR_W-1:0] REG_EFF_ZY = 8'h28;
  localparam logic [ADDR_W-1:0] REG_GAIN_MIN = 8'h2c;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h30;

  // field positions
  localparam int unsigned LO_POS = 0;
  localparam int unsigned HI_POS = 16;
  localparam int unsigned COL_F_POS = 0;
  localparam int unsigned ROW_F_POS = 8;
  localparam int unsigned SKIP_F_POS = 16;
  localparam int unsigned CTRL_COLOUR = 0;
  localparam int unsigned CTRL_WIDE = 1;
  localparam int unsigned CTRL_NOHDEC = 2;

  // limits and reset values
  localparam logic [FAC_W-1:0] FAC_OFF = 6'h01;
  localparam logic [FAC_W-1:0] BIN_MAX = 6'h04;
  localparam logic [FAC_W-1:0] SKIP_MAX = 6'h20;
  localparam logic [FAC_W-1:0] SKIP_TWO = 6'h02;
  localparam logic [FAC_W-1:0] SKIP_FOUR = 6'h04;
  localparam logic [DIM_W-1:0] SENSOR_W = 16'h0800;
  localparam logic [DIM_W-1:0] SENSOR_H = 16'h0440;
  localparam logic [GAIN_W-1:0] GAIN_MIN_NORM = 12'h024;
  localparam logic [GAIN_W-1:0] GAIN_MIN_BIN = 12'h000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : bdg_pkg

// >>> rtl/bdg_div.sv
// combinational unsigned divide of a dimension by a small factor.
// assumes factor is nonzero; quotient truncates toward zero.
module bdg_div
  import bdg_pkg::*;
(
  input  wire logic [DIM_W-1:0] num_i,
  input  wire logic [FAC_W-1:0] den_i,
  output logic      [DIM_W-1:0] quo_o
);
  // restoring division keeps this small and free of a divider macro
  always_comb begin
    logic [DIM_W:0] rem;
    rem = '0;
    quo_o = '0;
    for (int i = DIM_W - 1; i >= 0; i--) begin
      rem = {rem[DIM_W-1:0], num_i[i]};
      if (rem >= {{(DIM_W+1-FAC_W){1'b0}}, den_i}) begin
        rem = rem - {{(DIM_W+1-FAC_W){1'b0}}, den_i};
        quo_o[i] = 1'b1;
      end
    end
  end
endmodule : bdg_div

// >>> rtl/bdg_rowsel.sv
// row selector: decides per row whether it passes on to transmit.
// assumes sof_i precedes the first row and eol_i marks each row end.
module bdg_rowsel
  import bdg_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [FAC_W-1:0] skip_i,
  input  wire logic             colour_i,
  input  wire logic             sof_i,
  input  wire logic             eol_i,
  output logic                  keep_o
);
  logic [FAC_W-1:0] grp_ff;
  logic             half_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      grp_ff  <= '0;
      half_ff <= 1'b0;
    end else if (sof_i) begin
      grp_ff  <= '0;
      half_ff <= 1'b0;
    end else if (eol_i) begin
      // colour counts pairs so the filter pattern stays whole
      if (colour_i && !half_ff) begin
        half_ff <= 1'b1;
      end else begin
        half_ff <= 1'b0;
        if (grp_ff + FAC_OFF >= skip_i) begin
          grp_ff <= '0;
        end else begin
          grp_ff <= grp_ff + FAC_OFF;
        end
      end
    end
  end

  // first row (or pair) of each group is kept; factor one keeps all
  assign keep_o = (skip_i <= FAC_OFF) || (grp_ff == '0);
endmodule : bdg_rowsel

// >>> rtl/bdg_top.sv
// binning and decimation geometry: apb registers, derived geometry
// and per-row pass/drop on the pixel stream.
// assumes apb master on clk_i; pixels arrive synchronous with a
// start-of-frame and an end-of-line strobe.
module bdg_top
  import bdg_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              pix_valid_i,
  input  wire logic [PIX_W-1:0]  pix_data_i,
  input  wire logic              pix_sof_i,
  input  wire logic              pix_eol_i,
  output logic                   out_valid_o,
  output logic      [PIX_W-1:0]  out_data_o,
  output logic                   out_sof_o,
  output logic                   out_eol_o,
  output logic      [GAIN_W-1:0] gain_min_o
);
  logic             colour_ff;
  logic             wide_ff;
  logic             nohdec_ff;
  logic [FAC_W-1:0] column_merge_factor_ff;
  logic [FAC_W-1:0] row_merge_factor_ff;
  logic [FAC_W-1:0] row_skip_factor_ff;
  logic [DIM_W-1:0] aoi_w_ff;
  logic [DIM_W-1:0] aoi_h_ff;
  logic [DIM_W-1:0] aoi_x_ff;
  logic [DIM_W-1:0] aoi_y_ff;
  logic [DIM_W-1:0] zone_x_ff;
  logic [DIM_W-1:0] zone_w_ff;
  logic [DIM_W-1:0] zone_y_ff;
  logic [DIM_W-1:0] zone_h_ff;
  logic [31:0]      nxt_prdata;
  logic             err_ff;

  logic             wr_acc;
  logic             rd_acc;
  logic             mapped;
  logic [FAC_W-1:0] wr_col;
  logic [FAC_W-1:0] wr_row;
  logic [FAC_W-1:0] wr_skip;
  logic             bin_ok;
  logic             skip_ok;
  logic             fac_wr;
  logic [FAC_W-1:0] nxt_row;
  logic [FAC_W-1:0] nxt_skip;
  logic [FAC_W-1:0] nxt_col;
  logic             fac_chg;
  logic [DIM_W-1:0] aoi_wr_w;
  logic [DIM_W-1:0] aoi_wr_h;

  // quotient wires, one divider per field
  localparam int unsigned NDIV = 10;
  logic [DIM_W-1:0] div_num [NDIV];
  logic [FAC_W-1:0] div_den [NDIV];
  logic [DIM_W-1:0] div_quo [NDIV];

  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = (wr_acc || rd_acc) && !mapped;

  always_comb begin
    case (paddr_i)
      REG_CTRL, REG_FACTOR, REG_AOI_SIZE, REG_AOI_OFS, REG_ZONE_X,
      REG_ZONE_Y, REG_EFF_RES, REG_EFF_AOI, REG_EFF_AOFS, REG_EFF_ZX,
      REG_EFF_ZY, REG_GAIN_MIN, REG_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign wr_col  = pwdata_i[COL_F_POS +: FAC_W];
  assign wr_row  = pwdata_i[ROW_F_POS +: FAC_W];
  assign wr_skip = pwdata_i[SKIP_F_POS +: FAC_W];
  assign fac_wr  = wr_acc && (paddr_i == REG_FACTOR);

  // out-of-range factors are rejected whole, leaving old values
  assign bin_ok = (wr_col >= FAC_OFF) && (wr_col <= BIN_MAX) &&
                  (wr_row >= FAC_OFF) && (wr_row <= BIN_MAX);
  always_comb begin
    if (wide_ff) begin
      skip_ok = (wr_skip >= FAC_OFF) && (wr_skip <= SKIP_MAX);
    end else begin
      skip_ok = (wr_skip == FAC_OFF) || (wr_skip == SKIP_TWO) ||
                (wr_skip == SKIP_FOUR);
    end
  end

  // the later-enabled of row binning and row skip wins
  always_comb begin
    nxt_col  = column_merge_factor_ff;
    nxt_row  = row_merge_factor_ff;
    nxt_skip = row_skip_factor_ff;
    if (fac_wr && bin_ok && skip_ok) begin
      nxt_col  = wr_col;
      nxt_row  = wr_row;
      nxt_skip = wr_skip;
      if (wr_row > FAC_OFF && wr_skip > FAC_OFF) begin
        if (row_merge_factor_ff > FAC_OFF) begin
          nxt_row = FAC_OFF;
        end else begin
          nxt_skip = FAC_OFF;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      colour_ff <= 1'b0;
      wide_ff   <= 1'b0;
      nohdec_ff <= 1'b0;
    end else if (wr_acc && paddr_i == REG_CTRL) begin
      colour_ff <= pwdata_i[CTRL_COLOUR];
      wide_ff   <= pwdata_i[CTRL_WIDE];
      nohdec_ff <= pwdata_i[CTRL_NOHDEC];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      column_merge_factor_ff <= FAC_OFF;
      row_merge_factor_ff    <= FAC_OFF;
      row_skip_factor_ff     <= FAC_OFF;
    end else begin
      column_merge_factor_ff <= nxt_col;
      row_merge_factor_ff    <= nxt_row;
      row_skip_factor_ff     <= nxt_skip;
    end
  end

  assign fac_chg = (nxt_col != column_merge_factor_ff) ||
                   (nxt_row != row_merge_factor_ff);

  // a size beyond the virtual sensor is cut back to its edge
  always_comb begin
    aoi_wr_w = pwdata_i[LO_POS +: DIM_W];
    aoi_wr_h = pwdata_i[HI_POS +: DIM_W];
    if (aoi_wr_w > div_quo[0]) begin
      aoi_wr_w = div_quo[0];
    end
    if (aoi_wr_h > div_quo[1]) begin
      aoi_wr_h = div_quo[1];
    end
  end

  // aoi is held in sensor pixels, a multiple of the bin factor; a
  // factor change re-grids it as floor(aoi / new) * new, so what the
  // floor cut off is not restored when binning is turned off
  function automatic logic [DIM_W-1:0] rescale(
    input logic [DIM_W-1:0] quo,
    input logic [FAC_W-1:0] fac
  );
    logic [DIM_W+FAC_W-1:0] prod;
    prod = quo * fac;
    return prod[DIM_W-1:0];
  endfunction : rescale

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aoi_w_ff <= SENSOR_W;
      aoi_h_ff <= SENSOR_H;
    end else if (wr_acc && paddr_i == REG_AOI_SIZE) begin
      // written in virtual units, stored in physical units
      aoi_w_ff <= rescale(aoi_wr_w, column_merge_factor_ff);
      aoi_h_ff <= rescale(aoi_wr_h, row_merge_factor_ff);
    end else if (fac_chg) begin
      // round trip through the binned grid drops the remainder
      aoi_w_ff <= rescale(div_quo[2], nxt_col);
      aoi_h_ff <= rescale(div_quo[3], nxt_row);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aoi_x_ff <= '0;
      aoi_y_ff <= '0;
    end else if (wr_acc && paddr_i == REG_AOI_OFS) begin
      aoi_x_ff <= rescale(pwdata_i[LO_POS +: DIM_W],
                          column_merge_factor_ff);
      aoi_y_ff <= rescale(pwdata_i[HI_POS +: DIM_W], row_merge_factor_ff);
    end else if (fac_chg) begin
      aoi_x_ff <= rescale(div_quo[4], nxt_col);
      aoi_y_ff <= rescale(div_quo[5], nxt_row);
    end
  end

  // zones stay in sensor pixels; only their REG_EFF_ZX/REG_EFF_ZY read-back is binned
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zone_x_ff <= '0;
      zone_w_ff <= '0;
    end else if (wr_acc && paddr_i == REG_ZONE_X) begin
      zone_x_ff <= pwdata_i[LO_POS +: DIM_W];
      zone_w_ff <= pwdata_i[HI_POS +: DIM_W];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zone_y_ff <= '0;
      zone_h_ff <= '0;
    end else if (wr_acc && paddr_i == REG_ZONE_Y) begin
      zone_y_ff <= pwdata_i[LO_POS +: DIM_W];
      zone_h_ff <= pwdata_i[HI_POS +: DIM_W];
    end
  end

  // divider operands: 0-1 sensor, 2-5 aoi, 6-9 zones
  always_comb begin
    div_num[0] = SENSOR_W;
    div_den[0] = column_merge_factor_ff;
    div_num[1] = SENSOR_H;
    div_den[1] = row_merge_factor_ff;
    // aoi uses the factor about to stand, so a change re-grids it
    div_num[2] = aoi_w_ff;
    div_den[2] = nxt_col;
    div_num[3] = aoi_h_ff;
    div_den[3] = nxt_row;
    div_num[4] = aoi_x_ff;
    div_den[4] = nxt_col;
    div_num[5] = aoi_y_ff;
    div_den[5] = nxt_row;
    div_num[6] = zone_x_ff;
    div_den[6] = column_merge_factor_ff;
    div_num[7] = zone_w_ff;
    div_den[7] = column_merge_factor_ff;
    div_num[8] = zone_y_ff;
    div_den[8] = row_merge_factor_ff;
    div_num[9] = zone_h_ff;
    div_den[9] = row_merge_factor_ff;
  end

  for (genvar g = 0; g < NDIV; g++) begin : g_div
    bdg_div u_div (
      .num_i (div_num[g]),
      .den_i (div_den[g]),
      .quo_o (div_quo[g])
    );
  end

  // minimum gain lowered only for mono with row binning
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gain_min_o <= GAIN_MIN_NORM;
    end else if (!colour_ff && row_merge_factor_ff > FAC_OFF) begin
      gain_min_o <= GAIN_MIN_BIN;
    end else begin
      gain_min_o <= GAIN_MIN_NORM;
    end
  end

  always_comb begin
    nxt_prdata = RD_ZERO;
    case (paddr_i)
      REG_CTRL: nxt_prdata = {29'h0, nohdec_ff, wide_ff, colour_ff};
      REG_FACTOR: begin
        nxt_prdata[COL_F_POS +: FAC_W]  = column_merge_factor_ff;
        nxt_prdata[ROW_F_POS +: FAC_W]  = row_merge_factor_ff;
        nxt_prdata[SKIP_F_POS +: FAC_W] = row_skip_factor_ff;
      end
      REG_AOI_SIZE: nxt_prdata = {div_quo[3], div_quo[2]};
      REG_AOI_OFS:  nxt_prdata = {div_quo[5], div_quo[4]};
      REG_ZONE_X:   nxt_prdata = {zone_w_ff, zone_x_ff};
      REG_ZONE_Y:   nxt_prdata = {zone_h_ff, zone_y_ff};
      REG_EFF_RES:  nxt_prdata = {div_quo[1], div_quo[0]};
      REG_EFF_AOI:  nxt_prdata = {div_quo[3], div_quo[2]};
      REG_EFF_AOFS: nxt_prdata = {div_quo[5], div_quo[4]};
      REG_EFF_ZX:   nxt_prdata = {div_quo[7], div_quo[6]};
      REG_EFF_ZY:   nxt_prdata = {div_quo[9], div_quo[8]};
      REG_GAIN_MIN: nxt_prdata = {20'h0, gain_min_o};
      REG_STATUS:   nxt_prdata = {31'h0, err_ff};
      default:      nxt_prdata = RD_ZERO;
    endcase
  end

  // read data latched at the end of the setup phase so it stays stable in access
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= RD_ZERO;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= nxt_prdata;
    end
  end

  // held until the next factor write: last factor write was rejected
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_ff <= 1'b0;
    end else if (fac_wr) begin
      err_ff <= !(bin_ok && skip_ok);
    end
  end

  logic keep;
  bdg_rowsel u_rowsel (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .skip_i   (row_skip_factor_ff),
    .colour_i (colour_ff),
    .sof_i    (pix_sof_i && pix_valid_i),
    .eol_i    (pix_eol_i && pix_valid_i),
    .keep_o   (keep)
  );

  // dropped rows never reach transmit, so fewer lines per frame
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      out_sof_o   <= 1'b0;
      out_eol_o   <= 1'b0;
    end else begin
      out_valid_o <= pix_valid_i && (keep || pix_sof_i);
      out_data_o  <= pix_data_i;
      out_sof_o   <= pix_valid_i && pix_sof_i;
      out_eol_o   <= pix_valid_i && pix_eol_i && (keep || pix_sof_i);
    end
  end
endmodule : bdg_top

// >>> tb/bdg_asserts.sv
// checker for bdg_top: apb answer and pixel stream timing.
// assumes only the top ports; bound at the foot of this file.
module bdg_asserts
  import bdg_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              pix_valid_i,
  input wire logic [PIX_W-1:0]  pix_data_i,
  input wire logic              pix_sof_i,
  input wire logic              out_valid_o,
  input wire logic [PIX_W-1:0]  out_data_o,
  input wire logic              out_sof_o,
  input wire logic              out_eol_o,
  input wire logic [GAIN_W-1:0] gain_min_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire acc = psel_i && penable_i;
  wire unm = (paddr_i > REG_STATUS) || (paddr_i[1:0] != 2'h0);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ready_access: assert property (acc |-> pready_o)
    else $error("pready low in access");
  a_err_unmapped: assert property (acc && unm |-> pslverr_o)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (acc && !unm |-> !pslverr_o)
    else $error("error on mapped access");
  a_gain_read: assert property (
    psel_i && !penable_i && !pwrite_i && paddr_i == REG_GAIN_MIN
    |=> prdata_o[GAIN_W-1:0] == gain_min_o)
    else $error("gain limit read mismatch");
  a_gain_level: assert property (
    gain_min_o == GAIN_MIN_NORM || gain_min_o == GAIN_MIN_BIN)
    else $error("gain limit off its two levels");
  a_out_delay: assert property (out_valid_o |-> $past(pix_valid_i))
    else $error("output valid without input");
  a_data_copy: assert property (
    out_valid_o |-> out_data_o == $past(pix_data_i))
    else $error("output pixel differs");
  a_sof_kept: assert property (
    pix_valid_i && pix_sof_i |=> out_valid_o && out_sof_o)
    else $error("first row dropped");
  a_eol_qual: assert property (out_eol_o |-> out_valid_o)
    else $error("row end on dropped row");
  c_row_end: cover property (out_valid_o && out_eol_o);
  c_bus_err: cover property (acc && pslverr_o);
  c_gain_low: cover property (gain_min_o == GAIN_MIN_BIN);
endmodule : bdg_asserts
bind bdg_top bdg_asserts bdg_asserts_i(
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .pix_valid_i(pix_valid_i), .pix_data_i(pix_data_i),
  .pix_sof_i(pix_sof_i), .out_valid_o(out_valid_o),
  .out_data_o(out_data_o), .out_sof_o(out_sof_o),
  .out_eol_o(out_eol_o), .gain_min_o(gain_min_o));

// >>> tb/bdg_sensor_model.sv
// sensor readout model: 8 rows of 4 pixels per frame on each go pulse.
// assumes go_i is a one-cycle pulse given after reset.
module bdg_sensor_model
  import bdg_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             go_i,
  input  wire logic             gap_i,
  output logic                  pix_valid_o,
  output logic      [PIX_W-1:0] pix_data_o,
  output logic                  pix_sof_o,
  output logic                  pix_eol_o,
  output logic                  busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pix_valid_o = 1'b0;
    pix_data_o = 12'h000;
    pix_sof_o = 1'b0;
    pix_eol_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        busy_o <= 1'b1;
        for (int r = 0; r < 8; r++) begin
          for (int c = 0; c < 4; c++) begin
            pix_valid_o <= 1'b1;
            pix_data_o <= {r[5:0], c[5:0]};
            pix_sof_o <= (r == 0 && c == 0);
            pix_eol_o <= (c == 3);
            @(posedge clk_i);
            if (gap_i === 1'b1) begin
              // slow readout: idle data inverts so a stale copy shows
              pix_valid_o <= 1'b0;
              pix_data_o <= ~pix_data_o;
              @(posedge clk_i);
            end
          end
        end
        pix_valid_o <= 1'b0;
        pix_sof_o <= 1'b0;
        pix_eol_o <= 1'b0;
        // after a gap the data is already inverted; keep it so
        if (gap_i !== 1'b1) begin
          pix_data_o <= ~pix_data_o;
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule : bdg_sensor_model

// >>> tb/bdg_top_tb.sv
// testbench for bdg_top: apb master, sensor model, row checks.
// assumes the checker is bound to bdg_top by its own file.
module bdg_top_tb
  import bdg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, rst_n, psel, penable, pwrite, go, gap;
  logic              pready, pslverr, err, ov, osof, oeol;
  logic              pv, psof, peol, busy;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [PIX_W-1:0]  pd, od;
  logic [GAIN_W-1:0] gmin;
  logic [7:0]        kept;
  int                failures, check_count, npix, nsof;

  bdg_top bdg_top_i(.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pix_valid_i(pv), .pix_data_i(pd),
    .pix_sof_i(psof), .pix_eol_i(peol), .out_valid_o(ov),
    .out_data_o(od), .out_sof_o(osof), .out_eol_o(oeol),
    .gain_min_o(gmin));
  bdg_sensor_model bdg_sensor_model_i(.clk_i(clk), .go_i(go),
    .gap_i(gap), .pix_valid_o(pv), .pix_data_o(pd),
    .pix_sof_o(psof), .pix_eol_o(peol), .busy_o(busy));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (ov === 1'b1) begin
      npix++;
      if (osof === 1'b1) nsof++;
      if (oeol === 1'b1) kept[od[8:6]] = 1'b1;
    end
  end

  task results;
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one transfer; an idle cycle always follows the release
  task apb(input logic w, input logic [ADDR_W-1:0] a,
           input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk

  task t_reset;
    rdchk(REG_EFF_RES, {SENSOR_H, SENSOR_W});
    rdchk(REG_FACTOR, 32'h0001_0101);
    chk({20'h0, gmin}, {20'h0, GAIN_MIN_NORM});
  endtask : t_reset

  task t_bin;
    apb(1'b1, REG_ZONE_X, 32'h0010_000a);
    apb(1'b1, REG_ZONE_Y, 32'h0006_0006);
    apb(1'b1, REG_AOI_SIZE, 32'h01f4_03e8);
    apb(1'b1, REG_AOI_OFS, 32'h0014_000a);
    apb(1'b1, REG_FACTOR, 32'h0001_0303);
    rdchk(REG_EFF_RES, 32'h016a_02aa);
    rdchk(REG_AOI_SIZE, 32'h00a6_014d);
    rdchk(REG_AOI_OFS, 32'h0006_0003);
    rdchk(REG_EFF_ZX, 32'h0005_0003);
    rdchk(REG_EFF_ZY, 32'h0002_0002);
    apb(1'b1, REG_AOI_SIZE, 32'hffff_ffff);
    rdchk(REG_AOI_SIZE, 32'h016a_02aa);
    apb(1'b1, REG_AOI_SIZE, 32'h00a6_014d);
    chk({20'h0, gmin}, {20'h0, GAIN_MIN_BIN});
    rdchk(REG_GAIN_MIN, {20'h0, GAIN_MIN_BIN});
    apb(1'b1, REG_FACTOR, 32'h0001_0101);
    rdchk(REG_AOI_SIZE, 32'h01f2_03e7);
    rdchk(REG_AOI_OFS, 32'h0012_0009);
    rdchk(REG_EFF_RES, {SENSOR_H, SENSOR_W});
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    apb(1'b1, REG_FACTOR, 32'h0001_0201);
    chk({20'h0, gmin}, {20'h0, GAIN_MIN_NORM});
    rdchk(REG_GAIN_MIN, {20'h0, GAIN_MIN_NORM});
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    apb(1'b1, REG_FACTOR, 32'h0001_0101);
  endtask : t_bin

  task t_excl;
    apb(1'b1, REG_FACTOR, 32'h0001_0201);
    apb(1'b1, REG_FACTOR, 32'h0002_0201);
    rdchk(REG_FACTOR, 32'h0002_0101);
    apb(1'b1, REG_FACTOR, 32'h0002_0102);
    rdchk(REG_FACTOR, 32'h0002_0102);
    apb(1'b1, REG_FACTOR, 32'h0002_0202);
    rdchk(REG_FACTOR, 32'h0001_0202);
  endtask : t_excl

  task t_refuse;
    apb(1'b1, REG_FACTOR, 32'h0001_0101);
    apb(1'b1, REG_FACTOR, 32'h0003_0101);
    rdchk(REG_STATUS, 32'h0000_0001);
    rdchk(REG_FACTOR, 32'h0001_0101);
    apb(1'b1, REG_FACTOR, 32'h0004_0101);
    rdchk(REG_FACTOR, 32'h0004_0101);
    rdchk(REG_STATUS, 32'h0000_0000);
    apb(1'b1, REG_CTRL, 32'h0000_0002);
    apb(1'b1, REG_FACTOR, 32'h0021_0101);
    rdchk(REG_FACTOR, 32'h0004_0101);
    apb(1'b1, REG_FACTOR, 32'h0020_0101);
    rdchk(REG_FACTOR, 32'h0020_0101);
    apb(1'b1, REG_FACTOR, 32'h0001_0105);
    rdchk(REG_STATUS, 32'h0000_0001);
    apb(1'b1, REG_EFF_RES, 32'hffff_ffff);
    rdchk(REG_EFF_RES, {SENSOR_H, SENSOR_W});
    rdchk(8'h34, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
  endtask : t_refuse

  // kept rows come from the row index carried in each pixel
  task row_case(input logic c, input logic g, input logic [5:0] n);
    logic [7:0] m;
    int k;
    int w;
    m = 8'h00;
    k = 0;
    for (int r = 0; r < 8; r++) begin
      if (((c ? r / 2 : r) % n) == 0) begin
        m[r] = 1'b1;
        k++;
      end
    end
    apb(1'b1, REG_CTRL, {30'h0, 1'b1, c});
    apb(1'b1, REG_FACTOR, {10'h0, n, 16'h0101});
    kept = 8'h00;
    npix = 0;
    nsof = 0;
    gap <= g;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (busy !== 1'b0 && w < 200);
    if (w >= 200) begin
      failures++;
      results();
    end
    repeat (3) @(posedge clk);
    chk({24'h0, kept}, {24'h0, m});
    chk(32'(npix), 32'(k * 4));
    chk(32'(nsof), 32'h0000_0001);
  endtask : row_case

  task t_rows;
    row_case(1'b0, 1'b0, 6'h01);
    row_case(1'b1, 1'b0, 6'h01);
    row_case(1'b0, 1'b1, 6'h02);
    row_case(1'b1, 1'b0, 6'h02);
    row_case(1'b0, 1'b0, 6'h03);
    row_case(1'b1, 1'b1, 6'h04);
    row_case(1'b0, 1'b0, 6'h20);
  endtask : t_rows

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    go = 1'b0;
    gap = 1'b0;
    kept = 8'h00;
    failures = 0;
    check_count = 0;
    npix = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_bin;
    t_excl;
    t_refuse;
    t_rows;
    results;
  end
endmodule : bdg_top_tb
